// ---- core/efc_capture.sv ----
// encoder marker/freeze capture block with apb register file
//
// Local design decisions: the placing of the registers and the APB register port.
`timescale 1ns/1ps
module efc_capture #(
	parameter int UPDATE_CYCLES = efc_pkg::UPDATE_CYCLES
) (
	input wire logic core_clk_i,
	input wire logic nrst_i,
	input wire efc_pkg::efc_apb_req_type apb_req_i,
	output efc_pkg::efc_apb_rsp_type apb_rsp_o,
	input wire efc_pkg::efc_enc_type [efc_pkg::NUM_SRC-1:0] fb_enc_i,
	input wire efc_pkg::efc_enc_type [efc_pkg::NUM_SRC-1:0] ref_enc_i,
	input wire logic [efc_pkg::NUM_SRC-1:0] fb_marker_i,
	input wire logic [efc_pkg::NUM_SRC-1:0] ref_marker_i,
	input wire logic freeze_i,
	output logic [3:0] event_task_o
);

	// ****************************************************************
	// state
	// ****************************************************************
	typedef struct packed {
		logic [efc_pkg::NUM_ENC-1:0][31:0] live_tc;
		logic [efc_pkg::NUM_ENC-1:0][31:0] frz_tc;
		logic [efc_pkg::NUM_ENC-1:0][31:0] mk_tc;
		logic [31:0] ref_mk_pos;
		logic [15:0] ref_mk_turns;
		logic [15:0] ev_trig;
		logic [efc_pkg::NUM_ENC-1:0] mk_flag;
		logic [efc_pkg::NUM_ENC-1:0] mk_en;
		logic [efc_pkg::NUM_ENC-1:0] frz_flag;
		logic [efc_pkg::NUM_ENC-1:0] frz_en;
		logic [efc_pkg::NUM_ENC-1:0][7:0] src;
		logic [efc_pkg::NUM_PINS-1:0] pin_prev;
		logic [13:0] tick_cnt;
		logic [3:0] ev_pulse;
		efc_pkg::efc_apb_rsp_type rsp;
	} efc_state_type;

	localparam logic [13:0] TICK_LAST = 14'(UPDATE_CYCLES - 1);

	efc_state_type st;
	efc_state_type next_st;
	logic [efc_pkg::NUM_PINS-1:0] pins_s;
	efc_pkg::efc_enc_type [efc_pkg::NUM_ENC-1:0][efc_pkg::NUM_SRC-1:0] enc_all;

	// one driver for the whole array; the reference encoder sits in the upper entry
	assign enc_all = {ref_enc_i, fb_enc_i};

	// ****************************************************************
	// pin synchronisers
	// ****************************************************************
	efc_sync #(
		.WIDTH(efc_pkg::NUM_PINS)
	) u_sync (
		.core_clk_i(core_clk_i),
		.nrst_i(nrst_i),
		.async_i({freeze_i, ref_marker_i, fb_marker_i}),
		.sync_o(pins_s)
	);

	// ****************************************************************
	// read mux
	// ****************************************************************
	function automatic logic [32:0] read_reg(input logic [7:0] addr, input efc_state_type s);
		logic [32:0] r;
		r = {1'b1, 32'h0000_0000};
		case (addr)
			efc_pkg::OFS_FB_LIVE: r[31:0] = s.live_tc[efc_pkg::ENC_FB];
			efc_pkg::OFS_REF_LIVE: r[31:0] = s.live_tc[efc_pkg::ENC_REF];
			efc_pkg::OFS_FB_FRZ_TC: r[31:0] = s.frz_tc[efc_pkg::ENC_FB];
			efc_pkg::OFS_REF_FRZ_TC: r[31:0] = s.frz_tc[efc_pkg::ENC_REF];
			efc_pkg::OFS_REF_MK_POS: r[31:0] = s.ref_mk_pos;
			efc_pkg::OFS_REF_MK_TURNS: r[15:0] = s.ref_mk_turns;
			efc_pkg::OFS_FB_MK_TC: r[31:0] = s.mk_tc[efc_pkg::ENC_FB];
			efc_pkg::OFS_REF_MK_TC: r[31:0] = s.mk_tc[efc_pkg::ENC_REF];
			efc_pkg::OFS_EV_TRIG: r[15:0] = s.ev_trig;
			efc_pkg::OFS_REF_MK_FLAG: r[0] = s.mk_flag[efc_pkg::ENC_REF];
			efc_pkg::OFS_FB_MK_FLAG: r[0] = s.mk_flag[efc_pkg::ENC_FB];
			efc_pkg::OFS_REF_SRC: r[7:0] = s.src[efc_pkg::ENC_REF];
			efc_pkg::OFS_FB_SRC: r[7:0] = s.src[efc_pkg::ENC_FB];
			efc_pkg::OFS_REF_MK_EN: r[0] = s.mk_en[efc_pkg::ENC_REF];
			efc_pkg::OFS_FB_MK_EN: r[0] = s.mk_en[efc_pkg::ENC_FB];
			efc_pkg::OFS_REF_FRZ_EN: r[0] = s.frz_en[efc_pkg::ENC_REF];
			efc_pkg::OFS_FB_FRZ_EN: r[0] = s.frz_en[efc_pkg::ENC_FB];
			efc_pkg::OFS_REF_FRZ_FLAG: r[0] = s.frz_flag[efc_pkg::ENC_REF];
			efc_pkg::OFS_FB_FRZ_FLAG: r[0] = s.frz_flag[efc_pkg::ENC_FB];
			default: r[32] = 1'b0;
		endcase
		return r;
	endfunction

	// ****************************************************************
	// next-state logic
	// ****************************************************************
	always_comb begin
		logic tick;
		logic wr;
		logic [7:0] wa;
		logic [31:0] wd;
		logic [efc_pkg::NUM_PINS-1:0] rise;
		logic [efc_pkg::NUM_ENC-1:0] cfg;
		logic [efc_pkg::NUM_ENC-1:0] mk_rise;
		logic [efc_pkg::NUM_ENC-1:0] set_mk;
		logic [efc_pkg::NUM_ENC-1:0] set_frz;
		logic frz_rise;
		logic [32:0] rd;
		efc_pkg::efc_enc_type [efc_pkg::NUM_ENC-1:0] sel;
		tick = 1'b0;
		wr = 1'b0;
		wa = apb_req_i.paddr;
		wd = apb_req_i.pwdata;
		rise = pins_s & ~st.pin_prev;
		cfg = '0;
		mk_rise = '0;
		set_mk = '0;
		set_frz = '0;
		frz_rise = rise[efc_pkg::PIN_FRZ];
		rd = '0;
		sel = '0;
		next_st = st;
		next_st.pin_prev = pins_s;
		next_st.ev_pulse = 4'h0;

		// base update tick paces the live position words
		if (st.tick_cnt == TICK_LAST) begin
			tick = 1'b1;
			next_st.tick_cnt = 14'h0000;
		end else begin
			next_st.tick_cnt = st.tick_cnt + 14'h0001;
		end

		// per-encoder source select, live update and captures
		for (int e = 0; e < efc_pkg::NUM_ENC; e++) begin
			// codes above unconfigured have no source either
			cfg[e] = st.src[e] < efc_pkg::SRC_UNCONF;
			if (cfg[e]) begin
				sel[e] = enc_all[e][st.src[e][2:0]];
				mk_rise[e] = (e == efc_pkg::ENC_FB) ?
					rise[efc_pkg::PIN_FB_LSB + int'(st.src[e][2:0])] :
					rise[efc_pkg::PIN_REF_LSB + int'(st.src[e][2:0])];
			end
			if (tick && cfg[e]) begin
				next_st.live_tc[e] = {sel[e].turns, sel[e].coarse};
			end
			// an armed, enabled marker flag holds its capture until re-armed
			if (cfg[e] && mk_rise[e] && !(st.mk_en[e] && st.mk_flag[e])) begin
				next_st.mk_tc[e] = {sel[e].turns, sel[e].coarse};
				if (e == efc_pkg::ENC_REF) begin
					next_st.ref_mk_pos = sel[e].position;
					next_st.ref_mk_turns = sel[e].turns;
				end
			end
			set_mk[e] = cfg[e] && mk_rise[e] && st.mk_en[e];
			if (cfg[e] && frz_rise && !st.frz_flag[e]) begin
				next_st.frz_tc[e] = {sel[e].turns, sel[e].coarse};
				set_frz[e] = st.frz_en[e];
			end
		end

		// apb: write takes effect at the access edge with pready high
		wr = apb_req_i.psel && apb_req_i.penable && apb_req_i.pwrite && st.rsp.pready;
		if (wr) begin
			case (wa)
				efc_pkg::OFS_EV_TRIG: begin
					next_st.ev_trig = wd[15:0];
					case (wd[15:0])
						efc_pkg::EV_BASE: next_st.ev_pulse = 4'h1;
						efc_pkg::EV_ONE: next_st.ev_pulse = 4'h2;
						efc_pkg::EV_TWO: next_st.ev_pulse = 4'h4;
						efc_pkg::EV_THREE: next_st.ev_pulse = 4'h8;
						default: next_st.ev_pulse = 4'h0;
					endcase
				end
				efc_pkg::OFS_REF_MK_FLAG: begin
					if (!wd[0]) begin
						next_st.mk_flag[efc_pkg::ENC_REF] = 1'b0;
					end
				end
				efc_pkg::OFS_FB_MK_FLAG: begin
					if (!wd[0]) begin
						next_st.mk_flag[efc_pkg::ENC_FB] = 1'b0;
					end
				end
				efc_pkg::OFS_REF_FRZ_FLAG: begin
					if (!wd[0]) begin
						next_st.frz_flag[efc_pkg::ENC_REF] = 1'b0;
					end
				end
				efc_pkg::OFS_FB_FRZ_FLAG: begin
					if (!wd[0]) begin
						next_st.frz_flag[efc_pkg::ENC_FB] = 1'b0;
					end
				end
				efc_pkg::OFS_REF_SRC: next_st.src[efc_pkg::ENC_REF] = wd[7:0];
				efc_pkg::OFS_FB_SRC: next_st.src[efc_pkg::ENC_FB] = wd[7:0];
				efc_pkg::OFS_REF_MK_EN: next_st.mk_en[efc_pkg::ENC_REF] = wd[0];
				efc_pkg::OFS_FB_MK_EN: next_st.mk_en[efc_pkg::ENC_FB] = wd[0];
				efc_pkg::OFS_REF_FRZ_EN: next_st.frz_en[efc_pkg::ENC_REF] = wd[0];
				efc_pkg::OFS_FB_FRZ_EN: next_st.frz_en[efc_pkg::ENC_FB] = wd[0];
				default: ;
			endcase
		end

		// hardware set wins over a clear in the same cycle
		next_st.mk_flag = next_st.mk_flag | set_mk;
		next_st.frz_flag = next_st.frz_flag | set_frz;

		// answer one cycle after setup, so every bus output is a flop
		if (apb_req_i.psel && !apb_req_i.penable && !st.rsp.pready) begin
			rd = read_reg(wa, st);
			next_st.rsp.pready = 1'b1;
			next_st.rsp.pslverr = ~rd[32];
			next_st.rsp.prdata = apb_req_i.pwrite ? 32'h0000_0000 : rd[31:0];
		end else begin
			next_st.rsp = '0;
		end
	end

	// ****************************************************************
	// registers
	// ****************************************************************
	always_ff @(posedge core_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			st <= '0;
			st.ev_trig <= efc_pkg::EV_TRIG_RESET;
			st.src <= {efc_pkg::SRC_RESET, efc_pkg::SRC_RESET};
		end else begin
			st <= next_st;
		end
	end

	assign apb_rsp_o = st.rsp;
	assign event_task_o = st.ev_pulse;

endmodule // efc_capture

// ---- inc/efc_pkg.sv ----
// constants, carrier types and register map of the encoder marker/freeze capture block
// ****************************************************************
// ****************************************************************
package efc_pkg;

	// ****************************************************************
	// timing
	// ****************************************************************
	localparam int CLK_HZ = 50_000_000;
	localparam int UPDATE_US = 250;
	localparam int UPDATE_CYCLES = UPDATE_US * (CLK_HZ / 1_000_000);

	// ****************************************************************
	// encoder indices, sources and field positions
	// ****************************************************************
	localparam int ENC_FB = 0;
	localparam int ENC_REF = 1;
	localparam int NUM_ENC = 2;
	localparam int NUM_SRC = 5;
	localparam logic [7:0] SRC_DRIVE = 8'h00;
	localparam logic [7:0] SRC_SLOT1 = 8'h01;
	localparam logic [7:0] SRC_SLOT2 = 8'h02;
	localparam logic [7:0] SRC_SLOT3 = 8'h03;
	localparam logic [7:0] SRC_USER = 8'h04;
	localparam logic [7:0] SRC_UNCONF = 8'h05;
	localparam logic [7:0] SRC_RESET = SRC_UNCONF;
	localparam int TURNS_LSB = 16;
	localparam int COARSE_LSB = 0;
	localparam int PIN_FB_LSB = 0;
	localparam int PIN_REF_LSB = 5;
	localparam int PIN_FRZ = 10;
	localparam int NUM_PINS = 11;

	// ****************************************************************
	// event trigger codes
	// ****************************************************************
	localparam logic [15:0] EV_NONE = 16'h0000;
	localparam logic [15:0] EV_BASE = 16'h0001;
	localparam logic [15:0] EV_ONE = 16'h0002;
	localparam logic [15:0] EV_TWO = 16'h0003;
	localparam logic [15:0] EV_THREE = 16'h0004;
	localparam logic [15:0] EV_TRIG_RESET = EV_NONE;

	// ****************************************************************
	// register byte offsets
	// ****************************************************************
	localparam logic [7:0] OFS_FB_LIVE = 8'h00;
	localparam logic [7:0] OFS_REF_LIVE = 8'h04;
	localparam logic [7:0] OFS_FB_FRZ_TC = 8'h08;
	localparam logic [7:0] OFS_REF_FRZ_TC = 8'h0c;
	localparam logic [7:0] OFS_REF_MK_POS = 8'h10;
	localparam logic [7:0] OFS_REF_MK_TURNS = 8'h14;
	localparam logic [7:0] OFS_FB_MK_TC = 8'h18;
	localparam logic [7:0] OFS_REF_MK_TC = 8'h1c;
	localparam logic [7:0] OFS_EV_TRIG = 8'h20;
	localparam logic [7:0] OFS_REF_MK_FLAG = 8'h24;
	localparam logic [7:0] OFS_FB_MK_FLAG = 8'h28;
	localparam logic [7:0] OFS_REF_SRC = 8'h2c;
	localparam logic [7:0] OFS_FB_SRC = 8'h30;
	localparam logic [7:0] OFS_REF_MK_EN = 8'h34;
	localparam logic [7:0] OFS_FB_MK_EN = 8'h38;
	localparam logic [7:0] OFS_REF_FRZ_EN = 8'h3c;
	localparam logic [7:0] OFS_FB_FRZ_EN = 8'h40;
	localparam logic [7:0] OFS_REF_FRZ_FLAG = 8'h44;
	localparam logic [7:0] OFS_FB_FRZ_FLAG = 8'h48;

	// ****************************************************************
	// carrier types
	// ****************************************************************
	typedef struct packed {
		logic [15:0] turns;
		logic [15:0] coarse;
		logic [31:0] position;
	} efc_enc_type;

	typedef struct packed {
		logic psel;
		logic penable;
		logic pwrite;
		logic [7:0] paddr;
		logic [31:0] pwdata;
	} efc_apb_req_type;

	typedef struct packed {
		logic pready;
		logic [31:0] prdata;
		logic pslverr;
	} efc_apb_rsp_type;

endpackage

// ---- core/efc_sync.sv ----
// two-flop synchroniser for the marker and freeze pins
`timescale 1ns/1ps
module efc_sync #(
	parameter int WIDTH = 1
) (
	input wire logic core_clk_i,
	input wire logic nrst_i,
	input wire logic [WIDTH-1:0] async_i,
	output logic [WIDTH-1:0] sync_o
);
	logic [WIDTH-1:0] meta;

	// ****************************************************************
	// one pair of flops per bit; meta feeds only the second flop
	// ****************************************************************
	for (genvar b = 0; b < WIDTH; b++) begin : g_bit
		always_ff @(posedge core_clk_i or negedge nrst_i) begin
			if (!nrst_i) begin
				meta[b] <= 1'b0;
				sync_o[b] <= 1'b0;
			end else begin
				meta[b] <= async_i[b];
				sync_o[b] <= meta[b];
			end
		end
	end
endmodule // efc_sync

// ---- bench/efc_capture_assertions.sv ----
// apb timing and event pulse checks at the capture block's ports
`timescale 1ns/1ps
module efc_capture_assertions #(
	parameter int UPDATE_CYCLES = 16
) (
	input wire logic core_clk_i,
	input wire logic nrst_i,
	input wire efc_pkg::efc_apb_req_type apb_req_i,
	input wire efc_pkg::efc_apb_rsp_type apb_rsp_o,
	input wire efc_pkg::efc_enc_type [efc_pkg::NUM_SRC-1:0] fb_enc_i,
	input wire efc_pkg::efc_enc_type [efc_pkg::NUM_SRC-1:0] ref_enc_i,
	input wire logic [efc_pkg::NUM_SRC-1:0] fb_marker_i,
	input wire logic [efc_pkg::NUM_SRC-1:0] ref_marker_i,
	input wire logic freeze_i,
	input wire logic [3:0] event_task_o
);
	default clocking @(posedge core_clk_i); endclocking
	default disable iff (!nrst_i);
	logic acc;
	logic trig;
	assign acc = apb_req_i.psel && apb_req_i.penable && apb_rsp_o.pready;
	assign trig = acc && apb_req_i.pwrite && apb_req_i.paddr == efc_pkg::OFS_EV_TRIG;
	a_ready_after_setup: assert property (apb_req_i.psel && !apb_req_i.penable && !apb_rsp_o.pready
		|=> apb_rsp_o.pready) else $error("no ready after setup");
	a_ready_one_cycle: assert property (apb_rsp_o.pready |=> !apb_rsp_o.pready) else $error("ready held");
	a_err_unmapped: assert property (acc && apb_req_i.paddr > 8'h48 |-> apb_rsp_o.pslverr)
		else $error("unmapped address accepted");
	a_err_mapped: assert property (acc && apb_req_i.paddr <= 8'h48 && apb_req_i.paddr[1:0] == 2'h0
		|-> !apb_rsp_o.pslverr) else $error("mapped address refused");
	a_event_cause: assert property (event_task_o != 4'h0 |-> $past(trig)) else $error("stray task pulse");
	a_event_base: assert property (trig && apb_req_i.pwdata[15:0] == efc_pkg::EV_BASE
		|=> event_task_o == 4'h1 ##1 event_task_o == 4'h0) else $error("base task pulse");
	a_event_three: assert property (trig && apb_req_i.pwdata[15:0] == efc_pkg::EV_THREE
		|=> event_task_o == 4'h8) else $error("task three pulse");
	a_event_none: assert property (trig && (apb_req_i.pwdata[15:0] == efc_pkg::EV_NONE
		|| apb_req_i.pwdata[15:0] > efc_pkg::EV_THREE) |=> event_task_o == 4'h0) else $error("pulse on idle code");
	a_rsp_idle_zero: assert property (!apb_rsp_o.pready |-> apb_rsp_o.prdata == 32'h0000_0000 && !apb_rsp_o.pslverr)
		else $error("response outside access cycle");
endmodule // efc_capture_assertions

// ---- bench/efc_enc_model.sv ----
// behavioural feedback and reference encoders with marker and freeze pins
`timescale 1ns/1ps
module efc_enc_model (
	input wire logic core_clk_i,
	input wire logic nrst_i,
	input wire logic [3:0] seq_i,
	input wire logic [4:0] fb_req_i,
	input wire logic [4:0] ref_req_i,
	input wire logic frz_req_i,
	output efc_pkg::efc_enc_type [efc_pkg::NUM_SRC-1:0] fb_enc_o,
	output efc_pkg::efc_enc_type [efc_pkg::NUM_SRC-1:0] ref_enc_o,
	output logic [4:0] fb_marker_o,
	output logic [4:0] ref_marker_o,
	output logic freeze_o
);
	logic [10:0] p1;
	logic [10:0] p2;
	// pins high two cycles then low, so the synchroniser sees a gap
	always_ff @(posedge core_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			p1 <= 11'h000;
			p2 <= 11'h000;
		end else begin
			p1 <= {frz_req_i, ref_req_i, fb_req_i};
			p2 <= p1;
		end
	end
	assign {freeze_o, ref_marker_o, fb_marker_o} = p1 | p2;
	// every source shows a distinct word, so a wrong select is visible
	always_comb begin
		for (int i = 0; i < 5; i++) begin
			fb_enc_o[i].turns = 16'h1000 + {seq_i, 8'h00} + 16'(i);
			fb_enc_o[i].coarse = 16'hc000 + {seq_i, 4'h0} + 16'(i * 3);
			fb_enc_o[i].position = ~{fb_enc_o[i].turns, fb_enc_o[i].coarse};
			ref_enc_o[i].turns = 16'h1000 + {seq_i, 8'h00} + 16'(i + 8);
			ref_enc_o[i].coarse = 16'hc000 + {seq_i, 4'h0} + 16'((i + 8) * 3);
			ref_enc_o[i].position = ~{ref_enc_o[i].turns, ref_enc_o[i].coarse};
		end
	end
endmodule // efc_enc_model

// ---- bench/efc_capture_tb.sv ----
// self-checking bench of the capture block
`timescale 1ns/1ps
module efc_capture_tb;
	localparam int UPDATE_CYCLES = 16;
	typedef struct packed {logic w; logic [7:0] a; logic [31:0] d; logic [31:0] x; logic e; logic [3:0] v;} efc_row_type;
	logic core_clk_i = 1'b0;
	logic nrst_i = 1'b0;
	efc_pkg::efc_apb_req_type req = '0;
	efc_pkg::efc_apb_rsp_type rsp;
	efc_pkg::efc_enc_type [efc_pkg::NUM_SRC-1:0] fbe;
	efc_pkg::efc_enc_type [efc_pkg::NUM_SRC-1:0] rfe;
	logic [4:0] fbm;
	logic [4:0] rfm;
	logic [4:0] fbq = 5'h00;
	logic [4:0] rfq = 5'h00;
	logic frz;
	logic frq = 1'b0;
	logic [3:0] seq = 4'h0;
	logic [3:0] ev;
	logic [3:0] evs;
	logic [31:0] r;
	logic e;
	int fail_count = 0;
	int checked = 0;
	efc_row_type rows [24];
	always #10 core_clk_i = ~core_clk_i;
	efc_capture #(.UPDATE_CYCLES(UPDATE_CYCLES)) dut (.core_clk_i(core_clk_i), .nrst_i(nrst_i), .apb_req_i(req),
		.apb_rsp_o(rsp), .fb_enc_i(fbe), .ref_enc_i(rfe), .fb_marker_i(fbm), .ref_marker_i(rfm),
		.freeze_i(frz), .event_task_o(ev));
	efc_enc_model encm (.core_clk_i(core_clk_i), .nrst_i(nrst_i), .seq_i(seq), .fb_req_i(fbq), .ref_req_i(rfq),
		.frz_req_i(frq), .fb_enc_o(fbe), .ref_enc_o(rfe), .fb_marker_o(fbm), .ref_marker_o(rfm), .freeze_o(frz));
	function automatic logic [31:0] pk(input int k, input logic [3:0] s);
		pk = {16'h1000 + {s, 8'h00} + 16'(k), 16'hc000 + {s, 4'h0} + 16'(k * 3)};
	endfunction
	task automatic stop_test;
		$display("checks %0d mismatches %0d", checked, fail_count);
		if (fail_count == 0 && checked > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] g, input logic [31:0] x);
		checked++;
		if (g !== x) begin
			fail_count++;
			$display("wrong value at %0t: got %h expected %h", $time, g, x);
		end
	endtask
	// entered just after a rising edge; request held until pready is sampled high, only the watchdog ends a hang
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] rd,
		output logic er);
		req.psel <= 1'b1;
		req.penable <= 1'b0;
		req.pwrite <= w;
		req.paddr <= a;
		req.pwdata <= d;
		@(posedge core_clk_i);
		req.penable <= 1'b1;
		do begin
			@(posedge core_clk_i);
		end while (rsp.pready !== 1'b1);
		rd = rsp.prdata;
		er = rsp.pslverr;
		req.psel <= 1'b0;
		req.penable <= 1'b0;
		// task pulses stand in the cycle after the access edge
		@(posedge core_clk_i);
		evs = ev;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] rd;
		logic er;
		apb(1'b1, a, d, rd, er);
	endtask
	task automatic rdc(input logic [7:0] a, input logic [31:0] x);
		logic [31:0] rd;
		logic er;
		apb(1'b0, a, 32'h0, rd, er);
		chk(rd, x);
	endtask
	task automatic pulse(input logic [4:0] f, input logic [4:0] g, input logic z);
		fbq <= f;
		rfq <= g;
		frq <= z;
		@(posedge core_clk_i);
		fbq <= 5'h00;
		rfq <= 5'h00;
		frq <= 1'b0;
		repeat (8) @(posedge core_clk_i);
	endtask
	initial begin
		#200_000;
		fail_count++;
		stop_test();
	end
	initial begin
		rows = '{'{1'h0, 8'h20, 32'h0, 32'h0, 1'h0, 4'h0}, '{1'h0, 8'h2c, 32'h0, 32'h5, 1'h0, 4'h0},
			'{1'h0, 8'h30, 32'h0, 32'h5, 1'h0, 4'h0}, '{1'h0, 8'h24, 32'h0, 32'h0, 1'h0, 4'h0},
			'{1'h0, 8'h28, 32'h0, 32'h0, 1'h0, 4'h0}, '{1'h0, 8'h44, 32'h0, 32'h0, 1'h0, 4'h0},
			'{1'h0, 8'h48, 32'h0, 32'h0, 1'h0, 4'h0}, '{1'h0, 8'h34, 32'h0, 32'h0, 1'h0, 4'h0},
			'{1'h1, 8'h24, 32'h1, 32'h0, 1'h0, 4'h0}, '{1'h0, 8'h24, 32'h0, 32'h0, 1'h0, 4'h0},
			'{1'h1, 8'h44, 32'h1, 32'h0, 1'h0, 4'h0}, '{1'h0, 8'h44, 32'h0, 32'h0, 1'h0, 4'h0},
			'{1'h1, 8'h10, 32'hffffffff, 32'h0, 1'h0, 4'h0}, '{1'h0, 8'h10, 32'h0, 32'h0, 1'h0, 4'h0},
			'{1'h0, 8'h4c, 32'h0, 32'h0, 1'h1, 4'h0}, '{1'h1, 8'h4c, 32'h1, 32'h0, 1'h1, 4'h0},
			'{1'h1, 8'h20, 32'h0, 32'h0, 1'h0, 4'h0}, '{1'h1, 8'h20, 32'h1, 32'h0, 1'h0, 4'h1},
			'{1'h1, 8'h20, 32'h2, 32'h0, 1'h0, 4'h2}, '{1'h1, 8'h20, 32'h3, 32'h0, 1'h0, 4'h4},
			'{1'h1, 8'h20, 32'h4, 32'h0, 1'h0, 4'h8}, '{1'h1, 8'h20, 32'h00010002, 32'h0, 1'h0, 4'h2},
			'{1'h1, 8'h20, 32'h5, 32'h0, 1'h0, 4'h0}, '{1'h0, 8'h20, 32'h0, 32'h5, 1'h0, 4'h0}};
		repeat (8) @(posedge core_clk_i);
		nrst_i <= 1'b1;
		@(posedge core_clk_i);
		foreach (rows[i]) begin
			apb(rows[i].w, rows[i].a, rows[i].d, r, e);
			chk(r, rows[i].x);
			chk(32'(e), 32'(rows[i].e));
			chk(32'(evs), 32'(rows[i].v));
		end
		for (int s = 0; s < 5; s++) begin
			wr(8'h30, 32'(s));
			wr(8'h2c, 32'(4 - s));
			repeat (40) @(posedge core_clk_i);
			rdc(8'h00, pk(s, seq));
			rdc(8'h04, pk(12 - s, seq));
		end
		for (int i = 0; i < 4; i++) wr(8'h34 + 8'(4 * i), 32'h1);
		seq <= 4'h1;
		pulse(5'h10, 5'h01, 1'b0);
		rdc(8'h18, pk(4, 1));
		rdc(8'h1c, pk(8, 1));
		rdc(8'h10, ~pk(8, 1));
		rdc(8'h14, pk(8, 1) >> 16);
		rdc(8'h24, 32'h1);
		rdc(8'h28, 32'h1);
		seq <= 4'h2;
		pulse(5'h10, 5'h00, 1'b0);
		rdc(8'h18, pk(4, 1));
		wr(8'h28, 32'h0);
		rdc(8'h28, 32'h0);
		wr(8'h38, 32'h0);
		pulse(5'h10, 5'h00, 1'b0);
		rdc(8'h28, 32'h0);
		seq <= 4'h3;
		pulse(5'h00, 5'h00, 1'b1);
		rdc(8'h08, pk(4, 3));
		rdc(8'h0c, pk(8, 3));
		rdc(8'h44, 32'h1);
		rdc(8'h48, 32'h1);
		seq <= 4'h4;
		pulse(5'h00, 5'h00, 1'b1);
		rdc(8'h08, pk(4, 3));
		wr(8'h48, 32'h0);
		pulse(5'h00, 5'h00, 1'b1);
		rdc(8'h08, pk(4, 4));
		rdc(8'h48, 32'h1);
		wr(8'h40, 32'h0);
		wr(8'h48, 32'h0);
		pulse(5'h00, 5'h00, 1'b1);
		rdc(8'h48, 32'h0);
		wr(8'h2c, 32'h5);
		wr(8'h24, 32'h0);
		wr(8'h44, 32'h0);
		seq <= 4'h5;
		pulse(5'h00, 5'h1f, 1'b1);
		rdc(8'h24, 32'h0);
		rdc(8'h44, 32'h0);
		rdc(8'h1c, pk(8, 1));
		rdc(8'h0c, pk(8, 3));
		// mid-run reset: sources, enables, captures and trigger fall back to reset values
		nrst_i <= 1'b0;
		repeat (2) @(posedge core_clk_i);
		nrst_i <= 1'b1;
		@(posedge core_clk_i);
		rdc(8'h30, 32'h5);
		rdc(8'h34, 32'h0);
		rdc(8'h0c, 32'h0);
		rdc(8'h20, 32'h0);
		stop_test();
	end
endmodule // efc_capture_tb
bind efc_capture efc_capture_assertions #(.UPDATE_CYCLES(UPDATE_CYCLES)) chk_i (.core_clk_i(core_clk_i),
	.nrst_i(nrst_i), .apb_req_i(apb_req_i), .apb_rsp_o(apb_rsp_o), .fb_enc_i(fb_enc_i), .ref_enc_i(ref_enc_i),
	.fb_marker_i(fb_marker_i), .ref_marker_i(ref_marker_i), .freeze_i(freeze_i), .event_task_o(event_task_o));
